// [bench/test_timer_one_osc_overflow_reset.sv]
// self-checking bench for the timer block and its crystal
// assumes the timer answers on AXI4-Lite two cycles after valid
`timescale 1ns/10ps
`include "tos_defines.svh"

module test_timer_one_osc_overflow_reset;
	logic        aclk, aresetn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, crystal_input_pin, low_power_osc_config;
	logic        osc_run, osc_low_power, sleep_req, wake_req, sec_run_mode;
	logic        sec_idle_mode, adc_enabled, overflow_irq, adc_start;
	int          mismatches, comparisons;

	tos_timer u_tos_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .crystal_input_pin,
		.low_power_osc_config, .osc_run, .osc_low_power, .sleep_req, .wake_req,
		.sec_run_mode, .sec_idle_mode, .adc_enabled, .overflow_irq, .adc_start);

	tos_crystal_model u_tos_crystal_model (.aclk, .aresetn, .osc_run, .crystal_input_pin);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("compares %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic ran_out();
		mismatches++;
		$display("BAD %0t wait ran out", $time);
		complete_run();
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string s);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h want %h", $time, s, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp, input string s);
		check_word({31'h0, got}, {31'h0, exp}, s);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// bus master: valids held until their own ready
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (n == 50) ran_out();
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (n == 50) ran_out();
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic xtal_rises(input int k);
		int n;
		logic prev;
		prev = crystal_input_pin;
		for (n = 0; n < 1000 && k > 0; n++) begin
			@(posedge aclk);
			if (crystal_input_pin === 1'b1 && prev === 1'b0) k--;
			prev = crystal_input_pin;
		end
		if (k > 0) ran_out();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset_values();
		logic [7:0] offs [6] = '{`TOS_OFF_TCTL, `TOS_OFF_CNTL, `TOS_OFF_CNTH,
			`TOS_OFF_PFLG, `TOS_OFF_CMPL, `TOS_OFF_CMOD};
		logic [7:0] exps [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rdr(offs[i]);
			check_word(rd, {24'h0, exps[i]}, "reset value");
		end
		rdr(8'h24);
		check_word({30'h0, rs}, {30'h0, `TOS_RESP_SLV}, "unmapped read");
		wr(8'h24, 8'h01);
		check_word({30'h0, rs}, {30'h0, `TOS_RESP_SLV}, "unmapped write");
		$display("reset values done");
	endtask

	task automatic test_osc();
		wr(`TOS_OFF_TCTL, 8'h08);
		tick(2);
		check_bit(osc_run, 1'b1, "osc on");
		low_power_osc_config <= 1'b1;
		tick(3);
		check_bit(osc_low_power, 1'b1, "low power");
		low_power_osc_config <= 1'b0;
		tick(3);
		check_bit(osc_low_power, 1'b0, "high power");
		wr(`TOS_OFF_TCTL, 8'h00);
		tick(2);
		check_bit(osc_run, 1'b0, "osc off");
		$display("osc enable done");
	endtask

	task automatic test_overflow();
		wr(`TOS_OFF_CNTH, 8'hff);
		wr(`TOS_OFF_CNTL, 8'hf0);
		wr(`TOS_OFF_TCTL, 8'h01);
		tick(30);
		wr(`TOS_OFF_TCTL, 8'h00);
		rdr(`TOS_OFF_CNTH);
		check_word(rd, 32'h0, "wrapped high");
		rdr(`TOS_OFF_PFLG);
		check_word(rd, 32'h1, "flag on wrap");
		check_bit(overflow_irq, 1'b0, "irq masked");
		wr(`TOS_OFF_PIEN, 8'h01);
		tick(2);
		check_bit(overflow_irq, 1'b1, "irq enabled");
		wr(`TOS_OFF_PFLG, 8'h01);
		rdr(`TOS_OFF_PFLG);
		check_word(rd, 32'h1, "flag kept");
		wr(`TOS_OFF_PFLG, 8'h00);
		rdr(`TOS_OFF_PFLG);
		check_word(rd, 32'h0, "flag cleared");
		check_bit(overflow_irq, 1'b0, "irq gone");
		$display("overflow done");
	endtask

	task automatic test_compare();
		int n;
		logic seen;
		wr(`TOS_OFF_CNTL, 8'h00);
		wr(`TOS_OFF_CMPL, 8'h05);
		wr(`TOS_OFF_CMPH, 8'h00);
		wr(`TOS_OFF_CMOD, {4'h0, `TOS_CMODE_SPEC});
		adc_enabled <= 1'b1;
		wr(`TOS_OFF_TCTL, 8'h01);
		for (n = 0; n < 40 && adc_start !== 1'b1; n++) tick(1);
		if (n == 40) ran_out();
		for (n = 1; n < 40; n++) begin
			tick(1);
			if (adc_start === 1'b1) break;
		end
		check_word(n, 32'd6, "trigger period");
		adc_enabled <= 1'b0;
		tick(1);
		seen = 1'b0;
		repeat (14) begin
			tick(1);
			seen |= adc_start;
		end
		check_bit(seen, 1'b0, "no start when off");
		wr(`TOS_OFF_TCTL, 8'h00);
		rdr(`TOS_OFF_CNTL);
		check_bit(rd < 32'd6, 1'b1, "count below period");
		rdr(`TOS_OFF_PFLG);
		check_word(rd, 32'h0, "no flag on trigger");
		// count write lands in the cycle the count meets compare
		wr(`TOS_OFF_CMPL, 8'h13);
		wr(`TOS_OFF_CNTL, 8'h10);
		wr(`TOS_OFF_TCTL, 8'h01);
		wr(`TOS_OFF_CNTL, 8'h40);
		wr(`TOS_OFF_TCTL, 8'h00);
		rdr(`TOS_OFF_CNTL);
		check_word({30'h0, rd[7:6]}, 32'h1, "write beats trigger");
		wr(`TOS_OFF_CMOD, 8'h00);
		$display("compare trigger done");
	endtask

	task automatic test_ext_source();
		wr(`TOS_OFF_CNTL, 8'h00);
		wr(`TOS_OFF_TCTL, 8'h08);
		xtal_rises(1);
		wr(`TOS_OFF_TCTL, 8'h0b);
		xtal_rises(3);
		tick(5);
		wr(`TOS_OFF_TCTL, 8'h08);
		rdr(`TOS_OFF_CNTL);
		check_word(rd, 32'h3, "edge count");
		// async counter with compare 1: trigger must not reset
		wr(`TOS_OFF_CMPL, 8'h01);
		wr(`TOS_OFF_CMOD, {4'h0, `TOS_CMODE_SPEC});
		wr(`TOS_OFF_CNTL, 8'h00);
		wr(`TOS_OFF_TCTL, 8'h0f);
		xtal_rises(4);
		tick(5);
		wr(`TOS_OFF_TCTL, 8'h08);
		rdr(`TOS_OFF_CNTL);
		check_word(rd, 32'h4, "no trigger reset when async");
		wr(`TOS_OFF_CMOD, 8'h00);
		$display("external source done");
	endtask

	task automatic test_power();
		wr(`TOS_OFF_OSCC, {6'h0, `TOS_SCS_TIMER});
		tick(3);
		check_bit(sec_run_mode, 1'b1, "secondary run");
		rdr(`TOS_OFF_TCTL);
		check_word(rd, 32'h48, "status in run");
		sleep_req <= 1'b1;
		tick(1);
		sleep_req <= 1'b0;
		tick(3);
		check_bit(sec_idle_mode, 1'b1, "secondary idle");
		check_bit(osc_run, 1'b1, "osc in idle");
		rdr(`TOS_OFF_TCTL);
		check_word(rd, 32'h48, "status in idle");
		wake_req <= 1'b1;
		tick(1);
		wake_req <= 1'b0;
		tick(3);
		check_bit(sec_idle_mode, 1'b0, "woken");
		wr(`TOS_OFF_OSCC, {6'h20, `TOS_SCS_TIMER});
		sleep_req <= 1'b1;
		tick(1);
		sleep_req <= 1'b0;
		tick(3);
		check_bit(sec_idle_mode, 1'b0, "sleep with idle bit set");
		check_bit(sec_run_mode, 1'b0, "run left for sleep");
		wake_req <= 1'b1;
		tick(1);
		wake_req <= 1'b0;
		tick(3);
		check_bit(sec_run_mode, 1'b1, "run after wake");
		wr(`TOS_OFF_OSCC, 8'h00);
		tick(3);
		check_bit(sec_run_mode, 1'b0, "primary again");
		rdr(`TOS_OFF_TCTL);
		check_word(rd, 32'h08, "status off");
		$display("power modes done");
	endtask

	task automatic test_rd16_prescale();
		wr(`TOS_OFF_TCTL, 8'h80);
		wr(`TOS_OFF_CNTH, 8'h34);
		wr(`TOS_OFF_CNTL, 8'h56);
		wr(`TOS_OFF_TCTL, 8'h00);
		rdr(`TOS_OFF_CNTH);
		check_word(rd, 32'h34, "buffered high write");
		rdr(`TOS_OFF_CNTL);
		check_word(rd, 32'h56, "buffered low write");
		wr(`TOS_OFF_TCTL, 8'h80);
		wr(`TOS_OFF_CNTH, 8'h77);
		rdr(`TOS_OFF_CNTL);
		rdr(`TOS_OFF_CNTH);
		check_word(rd, 32'h34, "high copied on low read");
		// 1:8 prescale, high write in mid-count must not clear it
		wr(`TOS_OFF_TCTL, 8'h30);
		wr(`TOS_OFF_CNTH, 8'h00);
		wr(`TOS_OFF_CNTL, 8'h00);
		wr(`TOS_OFF_TCTL, 8'h31);
		tick(1);
		wr(`TOS_OFF_CNTH, 8'h00);
		tick(25);
		wr(`TOS_OFF_TCTL, 8'h30);
		rdr(`TOS_OFF_CNTL);
		check_word(rd, 32'h4, "one in eight, no clear on high");
		wr(`TOS_OFF_TCTL, 8'h08);
		$display("rd16 and prescaler done");
	endtask

	task automatic test_mid_reset();
		wr(`TOS_OFF_CNTH, 8'h12);
		aresetn <= 1'b0;
		tick(4);
		aresetn <= 1'b1;
		tick(1);
		check_bit(osc_run, 1'b0, "osc after reset");
		rdr(`TOS_OFF_CNTH);
		check_word(rd, 32'h0, "count after reset");
		rdr(`TOS_OFF_TCTL);
		check_word(rd, 32'h0, "control after reset");
		$display("mid-run reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		{low_power_osc_config, sleep_req, wake_req, adc_enabled} = '0;
		s_axi_wstrb = 4'h1;
		mismatches = 0;
		comparisons = 0;
		tick(16);
		aresetn <= 1'b1;
		test_reset_values();
		test_osc();
		test_overflow();
		test_compare();
		test_ext_source();
		test_power();
		test_rd16_prescale();
		test_mid_reset();
		complete_run();
	end
endmodule

// [bench/tos_crystal_model.sv]
// crystal model: slow square wave on the count pin while driven
// assumes osc_run comes from the timer in the aclk domain
`timescale 1ns/10ps

module tos_crystal_model #(
	parameter int START = 20,
	parameter int HALF  = 50
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// oscillator
	input  wire logic osc_run,
	output logic      crystal_input_pin
);
	int unsigned ticks;

	////////////////////////////////////////////////////////////////////////////////
	// swings only while driven
	// no power mode input: a driven crystal never stops
	always_ff @(posedge aclk) begin
		if (!aresetn || !osc_run) begin
			ticks <= 0;
			crystal_input_pin <= 1'b0;
		end else begin
			ticks <= ticks + 1;
			if (ticks >= START && (ticks - START) % HALF == 0)
				crystal_input_pin <= ~crystal_input_pin;
		end
	end
endmodule

// [verilog/tos_defines.svh]
// offsets, field positions, reset values and mode codes of the timer block
// assumes a 32-bit AXI4-Lite register bus, one register per aligned word
`ifndef TOS_DEFINES_SVH
`define TOS_DEFINES_SVH

// register byte offsets
`define TOS_OFF_TCTL   8'h00
`define TOS_OFF_CNTL   8'h04
`define TOS_OFF_CNTH   8'h08
`define TOS_OFF_PFLG   8'h0c
`define TOS_OFF_PIEN   8'h10
`define TOS_OFF_OSCC   8'h14
`define TOS_OFF_CMPL   8'h18
`define TOS_OFF_CMPH   8'h1c
`define TOS_OFF_CMOD   8'h20

// timer_control_reg fields
`define TOS_TCTL_RD16  7
`define TOS_TCTL_STAT  6
`define TOS_TCTL_PSH   5
`define TOS_TCTL_PSL   4
`define TOS_TCTL_OSCEN 3
`define TOS_TCTL_NSYNC 2
`define TOS_TCTL_SRC   1
`define TOS_TCTL_ON    0

// oscillator_control_reg fields
`define TOS_OSCC_IDLE  7
`define TOS_OSCC_SCSH  1
`define TOS_OSCC_SCSL  0
`define TOS_SCS_TIMER  2'h1

// flag and enable bit position
`define TOS_OVF_BIT    0

// compare_mode_field code for special event trigger
`define TOS_CMODE_SPEC 4'hb

// reset values and the count maximum
`define TOS_RST_BYTE   8'h00
`define TOS_RST_CNT    16'h0000
`define TOS_CNT_MAX    16'hffff
`define TOS_RST_CMP    16'hffff
`define TOS_RST_CMODE  4'h0

// bus answers
`define TOS_RESP_OKAY  2'h0
`define TOS_RESP_SLV   2'h2

`endif

// [verilog/tos_pkg.sv]
// types shared by the timer block files
// assumes tos_defines.svh supplies all numeric constants
package tos_pkg;

	// power-managed clocking state
	typedef enum logic [1:0] {
		TOS_PM_PRIMARY,
		TOS_PM_SEC_RUN,
		TOS_PM_SEC_IDLE,
		TOS_PM_SLEEP
	} tos_pm_t;

endpackage

// [verilog/tos_prescaler.sv]
// count prescaler for the timer: passes one tick in 1, 2, 4 or 8
// assumes tick_in is a one-cycle pulse in the aclk domain
`timescale 1ns/10ps
`include "tos_defines.svh"

module tos_prescaler
	import tos_pkg::*;
#(
	parameter int WIDTH = 3
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// control
	input  wire logic             clear,
	input  wire logic [1:0]       sel,
	// ticks
	input  wire logic             tick_in,
	output logic                  tick_out
);

	logic [WIDTH-1:0] div_q;
	logic [WIDTH-1:0] mask;

	// sel 0 passes every tick, sel 3 one in eight
	assign mask     = WIDTH'((1 << sel) - 1);
	assign tick_out = tick_in && ((div_q & mask) == mask);

	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			div_q <= '0;
		end else if (tick_in) begin
			div_q <= div_q + WIDTH'(1);
		end
	end

endmodule

// [verilog/tos_timer.sv]
// 16-bit timer with low-speed oscillator control, overflow flag
// and compare special event reset, behind an AXI4-Lite slave
// assumes crystal_input_pin is already synchronous to aclk
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "tos_defines.svh"

module tos_timer
	import tos_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// oscillator and external clock
	input  wire logic        crystal_input_pin,
	input  wire logic        low_power_osc_config,
	output logic             osc_run,
	output logic             osc_low_power,
	// power management
	input  wire logic        sleep_req,
	input  wire logic        wake_req,
	output logic             sec_run_mode,
	output logic             sec_idle_mode,
	// interrupt request and converter trigger
	input  wire logic        adc_enabled,
	output logic             overflow_irq,
	output logic             adc_start
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0]  ctl_q;
	logic [15:0] cnt_q;
	logic [7:0]  hi_buf_q;
	logic        ovf_q;
	logic        ien_q;
	logic [7:0]  oscc_q;
	logic [15:0] cmp_q;
	logic [3:0]  cmode_q;
	logic        ext_prev_q;
	tos_pm_t     pm_q;
	logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic        osc_run_q, osc_lp_q, sec_run_q, sec_idle_q, irq_q, adc_q;
	logic        wr_en, rd_en;
	logic        wr_lo, wr_hi, wr_cnt;
	logic        raw_tick, tick, async_mode, trig, wrap;
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= `TOS_OFF_CMOD);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// axi4-lite slave: aw and w taken together, one cycle after both valid
	assign wr_en = awready_q;
	assign rd_en = arready_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `TOS_RESP_OKAY;
		end else begin
			awready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
			wready_q  <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
			if (wr_en) begin
				bvalid_q <= 1'b1;
				bresp_q  <= mapped(s_axi_awaddr) ? `TOS_RESP_OKAY : `TOS_RESP_SLV;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= `TOS_RESP_OKAY;
		end else begin
			arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
			if (rd_en) begin
				rvalid_q <= 1'b1;
				rresp_q  <= mapped(s_axi_araddr) ? `TOS_RESP_OKAY : `TOS_RESP_SLV;
				unique case (s_axi_araddr)
					`TOS_OFF_TCTL: rdata_q <= {24'h0, ctl_q[7], sec_run_q | sec_idle_q,
						ctl_q[5:0]};
					`TOS_OFF_CNTL: rdata_q <= {24'h0, cnt_q[7:0]};
					`TOS_OFF_CNTH: rdata_q <= {24'h0,
						ctl_q[`TOS_TCTL_RD16] ? hi_buf_q : cnt_q[15:8]};
					`TOS_OFF_PFLG: rdata_q <= {31'h0, ovf_q};
					`TOS_OFF_PIEN: rdata_q <= {31'h0, ien_q};
					`TOS_OFF_OSCC: rdata_q <= {24'h0, oscc_q};
					`TOS_OFF_CMPL: rdata_q <= {24'h0, cmp_q[7:0]};
					`TOS_OFF_CMPH: rdata_q <= {24'h0, cmp_q[15:8]};
					`TOS_OFF_CMOD: rdata_q <= {28'h0, cmode_q};
					default:       rdata_q <= 32'h0;
				endcase
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q   <= `TOS_RST_BYTE;
			ien_q   <= 1'b0;
			oscc_q  <= `TOS_RST_BYTE;
			cmp_q   <= `TOS_RST_CMP;
			cmode_q <= `TOS_RST_CMODE;
		end else if (wr_en && s_axi_wstrb[0]) begin
			unique case (s_axi_awaddr)
				`TOS_OFF_TCTL: ctl_q   <= s_axi_wdata[7:0] & 8'hbf;
				`TOS_OFF_PIEN: ien_q   <= s_axi_wdata[`TOS_OVF_BIT];
				`TOS_OFF_OSCC: oscc_q  <= s_axi_wdata[7:0] & 8'h83;
				`TOS_OFF_CMPL: cmp_q[7:0]  <= s_axi_wdata[7:0];
				`TOS_OFF_CMPH: cmp_q[15:8] <= s_axi_wdata[7:0];
				`TOS_OFF_CMOD: cmode_q <= s_axi_wdata[3:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// count source and prescaler
	assign wr_lo  = wr_en && s_axi_wstrb[0] && (s_axi_awaddr == `TOS_OFF_CNTL);
	assign wr_hi  = wr_en && s_axi_wstrb[0] && (s_axi_awaddr == `TOS_OFF_CNTH);
	assign wr_cnt = wr_lo || (wr_hi && !ctl_q[`TOS_TCTL_RD16]);
	assign async_mode = ctl_q[`TOS_TCTL_SRC] && ctl_q[`TOS_TCTL_NSYNC];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= crystal_input_pin;
		end
	end
	assign raw_tick = ctl_q[`TOS_TCTL_ON] && (!ctl_q[`TOS_TCTL_SRC] ||
		(crystal_input_pin && !ext_prev_q));
	tos_prescaler #(
		.WIDTH (3)
	) u_pre (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.clear    (wr_lo),
		.sel      (ctl_q[`TOS_TCTL_PSH:`TOS_TCTL_PSL]),
		.tick_in  (raw_tick),
		.tick_out (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// counter; trig itself blocks the special event reset in async mode
	// special event at compare value, not in async mode
	assign trig = (cmode_q == `TOS_CMODE_SPEC) && tick && (cnt_q == cmp_q) && !async_mode;
	assign wrap = tick && (cnt_q == `TOS_CNT_MAX) && !trig && !wr_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q    <= `TOS_RST_CNT;
			hi_buf_q <= `TOS_RST_BYTE;
		end else begin
			if (rd_en && (s_axi_araddr == `TOS_OFF_CNTL)) begin
				hi_buf_q <= cnt_q[15:8];
			end else if (wr_hi && ctl_q[`TOS_TCTL_RD16]) begin
				hi_buf_q <= s_axi_wdata[7:0];
			end
			if (wr_lo) begin
				cnt_q <= {ctl_q[`TOS_TCTL_RD16] ? hi_buf_q : cnt_q[15:8], s_axi_wdata[7:0]};
			end else if (wr_hi && !ctl_q[`TOS_TCTL_RD16]) begin
				cnt_q <= {s_axi_wdata[7:0], cnt_q[7:0]};
			end else if (trig) begin
				cnt_q <= `TOS_RST_CNT;
			end else if (tick) begin
				cnt_q <= cnt_q + 16'h1;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovf_q <= 1'b0;
		end else if (wrap) begin
			ovf_q <= 1'b1;
		end else if (wr_en && s_axi_wstrb[0] && (s_axi_awaddr == `TOS_OFF_PFLG) &&
			!s_axi_wdata[`TOS_OVF_BIT]) begin
			ovf_q <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// power-managed clock modes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pm_q <= TOS_PM_PRIMARY;
		end else begin
			unique case (pm_q)
				TOS_PM_PRIMARY, TOS_PM_SEC_RUN: begin
					if (sleep_req) begin
						pm_q <= (pm_q == TOS_PM_SEC_RUN && !oscc_q[`TOS_OSCC_IDLE]) ?
							TOS_PM_SEC_IDLE : TOS_PM_SLEEP;
					end else if (oscc_q[`TOS_OSCC_SCSH:`TOS_OSCC_SCSL] == `TOS_SCS_TIMER) begin
						pm_q <= TOS_PM_SEC_RUN;
					end else begin
						pm_q <= TOS_PM_PRIMARY;
					end
				end
				TOS_PM_SEC_IDLE, TOS_PM_SLEEP: begin
					if (wake_req) begin
						pm_q <= TOS_PM_PRIMARY;
					end
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_run_q  <= 1'b0;
			osc_lp_q   <= 1'b0;
			sec_run_q  <= 1'b0;
			sec_idle_q <= 1'b0;
			irq_q      <= 1'b0;
			adc_q      <= 1'b0;
		end else begin
			osc_run_q  <= ctl_q[`TOS_TCTL_OSCEN];
			osc_lp_q   <= low_power_osc_config;
			sec_run_q  <= (pm_q == TOS_PM_SEC_RUN);
			sec_idle_q <= (pm_q == TOS_PM_SEC_IDLE);
			irq_q      <= ovf_q && ien_q;
			adc_q      <= trig && adc_enabled;
		end
	end
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign osc_run       = osc_run_q;
	assign osc_low_power = osc_lp_q;
	assign sec_run_mode  = sec_run_q;
	assign sec_idle_mode = sec_idle_q;
	assign overflow_irq  = irq_q;
	assign adc_start     = adc_q;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_OSC_EN: assert property (osc_run == $past(ctl_q[`TOS_TCTL_OSCEN]))
		else $error("oscillator run differs from enable bit");
	AST_OSC_IDLE: assert property (sec_idle_mode && $past(ctl_q[3]) |-> osc_run)
		else $error("oscillator stopped in idle mode");
	AST_SEC_RUN: assert property (!sleep_req && oscc_q[1:0] == `TOS_SCS_TIMER &&
		pm_q != TOS_PM_SEC_IDLE && pm_q != TOS_PM_SLEEP |-> ##2 sec_run_mode)
		else $error("secondary run not entered");
	AST_SEC_IDLE: assert property (pm_q == TOS_PM_SEC_RUN && sleep_req && !oscc_q[7]
		|-> ##2 sec_idle_mode)
		else $error("secondary idle not entered");
	AST_STATUS: assert property (s_axi_rvalid && $rose(s_axi_rvalid) &&
		$past(s_axi_araddr, 2) == `TOS_OFF_TCTL |-> s_axi_rdata[6] ==
		($past(sec_run_mode) || $past(sec_idle_mode)))
		else $error("status bit wrong");
	AST_WRAP: assert property (tick && cnt_q == 16'hffff && !trig && !wr_cnt
		|=> cnt_q == 16'h0 && ovf_q)
		else $error("wrap did not clear count and set flag");
	AST_IRQ: assert property (overflow_irq |-> $past(ovf_q) && $past(ien_q))
		else $error("request without flag and enable");
	AST_TRIG: assert property (trig && !wr_cnt |=> cnt_q == 16'h0)
		else $error("trigger did not reset count");
	AST_ASYNC: assert property (async_mode && tick && !wr_cnt && cnt_q == cmp_q &&
		cmode_q == `TOS_CMODE_SPEC |=> cnt_q == $past(cnt_q) + 16'h1)
		else $error("trigger reset in asynchronous mode");
	AST_WR_WINS: assert property (wr_lo && trig |=> cnt_q[7:0] == $past(s_axi_wdata[7:0]))
		else $error("trigger beat software write");
	AST_NO_FLAG: assert property (trig && !ovf_q |=> !ovf_q)
		else $error("trigger set the overflow flag");
	AST_STICKY: assert property (ovf_q && !(wr_en && s_axi_awaddr == `TOS_OFF_PFLG)
		|=> ovf_q)
		else $error("flag dropped without clear");
	AST_ADC: assert property (trig && adc_enabled |=> adc_start)
		else $error("conversion not started");

endmodule
